//--- common/cwp_pkg.sv
/*
 Package for the configuration word protection decoder: config space
 addresses, field positions, blank values and decode enumerations.
 Assumes a 14-bit program word and a 16-bit address space.
*/
package cwp_pkg;

    localparam int          WORD_W         = 14;
    localparam int          ADDR_W         = 16;
    localparam logic [15:0] USER_ID_BASE   = 16'h8000;
    localparam logic [15:0] USER_ID_LAST   = 16'h8003;
    localparam logic [15:0] IDENTITY_ADDR  = 16'h8006;
    localparam logic [15:0] WORD_A_ADDR    = 16'h8007;
    localparam logic [15:0] WORD_B_ADDR    = 16'h8008;
    localparam logic [13:0] BLANK_WORD     = 14'h3FFF;
    localparam logic [13:0] WORD_B_FIXED   = 14'h08EC;
    localparam int          OSC_SEL_LSB    = 0;
    localparam int          PROG_PROT_BIT  = 7;
    localparam int          DATA_PROT_BIT  = 8;
    localparam int          GUARD_LSB      = 0;
    localparam int          MULT_EN_BIT    = 8;
    localparam int          STACK_RST_BIT  = 9;
    localparam int          BROWNOUT_BIT   = 10;
    localparam int          DEBUG_BIT      = 12;
    localparam int          LV_PROG_BIT    = 13;
    localparam int          PART_CODE_LSB  = 5;
    localparam int          REV_CODE_LSB   = 0;
    localparam logic [12:0] GUARD_END_SMALL = 13'h01FF;
    localparam logic [12:0] GUARD_END_HALF  = 13'h0FFF;
    localparam logic [12:0] GUARD_END_ALL   = 13'h1FFF;

    typedef enum logic [2:0] {
        OSC_LOW_POWER_CRYSTAL   = 3'h0,
        OSC_MEDIUM_GAIN_CRYSTAL = 3'h1,
        OSC_HIGH_GAIN_CRYSTAL   = 3'h2,
        OSC_EXTERNAL_RC         = 3'h3,
        OSC_INTERNAL            = 3'h4,
        OSC_EXT_CLOCK_LOW       = 3'h5,
        OSC_EXT_CLOCK_MEDIUM    = 3'h6,
        OSC_EXT_CLOCK_HIGH      = 3'h7
    } cwp_osc_t;

    typedef enum logic [1:0] {
        GUARD_ALL   = 2'h0,
        GUARD_HALF  = 2'h1,
        GUARD_SMALL = 2'h2,
        GUARD_NONE  = 2'h3
    } cwp_guard_t;

endpackage

//--- core/cwp_decode.sv
/*
 Configuration word decoder and protection gate. Holds the two option
 words, user ID words and identity word; gates programmer access and
 self-writes. Assumes the programmer port delivers single-cycle
 requests synchronous to clock and that flash arrays sit outside.
*/
// Function
// - Decode three-bit oscillator select into eight clock source modes.
// - Internal oscillator frees clock input pin; external clock modes route clock.
// - Bulk erase clears program flash, data EEPROM and configuration together.
// - Only programmer bulk erase clears data protection; that erase wipes EEPROM.
// - Low-voltage enable one allows low-voltage entry; zero requires high voltage.
// - Refuse programming low-voltage enable to zero while in low-voltage entry.
// - Debug bit one leaves programming pins general; zero dedicates them.
// - Brown-out select one picks low trip point, zero high.
// - Stack fault resets device only when its enable bit is one.
// - Multiplier enable bit turns the 4x frequency multiplier on or off.
// - Unimplemented bits 2, 3, 5-7 and 11 of second word read back as one; bit 4 reads back as programmed.
// - Self-write guard field blocks none, 1FFh, FFFh or 1FFFh ranges.
// - Program protection zero blocks external program writes; reads return zero.
// - Data protection zero blocks external EEPROM reads and writes.
// - Program and data protection act independently, each by its own bit.
// - Protection never restricts internal CPU program reads or EEPROM access.
// - Four user ID words at 8000h-8003h, readable and writable in run.
// - Read-only identity word at 8006h: part code high, revision low.
// - Programmable configuration bits read one when blank or after bulk erase.
// - First option word at 8007h, second at 8008h.
// - Data protection at bit 8, program protection at bit 7 of word a.
module cwp_decode #(
    parameter logic [8:0] PART_CODE = 9'h155,  // Arbitrary value
    parameter logic [4:0] REV_CODE  = 5'h01    // Arbitrary value
) (
    // Clock and reset
    input  wire logic                      clock,
    input  wire logic                      sys_rst,
    input  wire logic                      clk_en,
    // Programming entry status
    input  wire logic                      prog_mode,
    input  wire logic                      prog_entry_low_voltage,
    input  wire logic                      master_clear_pin_high_voltage,
    // Programmer access
    input  wire logic                      ext_req,
    input  wire logic                      ext_write,
    input  wire logic                      ext_eeprom,
    input  wire logic [cwp_pkg::ADDR_W-1:0] ext_addr,
    input  wire logic [cwp_pkg::WORD_W-1:0] ext_wdata,
    input  wire logic                      ext_bulk_erase,
    input  wire logic [cwp_pkg::WORD_W-1:0] ext_array_rdata,
    output logic [cwp_pkg::WORD_W-1:0]      ext_rdata,
    output logic                           ext_array_read,
    output logic                           ext_array_write,
    output logic                           ext_refused,
    output logic                           erase_program_flash,
    output logic                           erase_data_eeprom,
    // CPU access
    input  wire logic                      cpu_req,
    input  wire logic                      cpu_write,
    input  wire logic                      cpu_eeprom,
    input  wire logic [cwp_pkg::ADDR_W-1:0] cpu_addr,
    input  wire logic [cwp_pkg::WORD_W-1:0] cpu_wdata,
    input  wire logic [cwp_pkg::WORD_W-1:0] cpu_array_rdata,
    output logic [cwp_pkg::WORD_W-1:0]      cpu_rdata,
    output logic                           cpu_array_read,
    output logic                           cpu_array_write,
    output logic                           cpu_write_blocked,
    // Stack faults
    input  wire logic                      stack_overflow,
    input  wire logic                      stack_underflow,
    output logic                           stack_fault_reset,
    // Decoded controls
    output cwp_pkg::cwp_osc_t              oscillator_select,
    output logic                           clock_input_pin_is_io,
    output logic                           clock_input_pin_is_clock,
    output logic                           resonator_pins_crystal,
    output logic                           low_voltage_prog_enable,
    output logic                           prog_entry_allowed,
    output logic                           debug_pins_dedicated,
    output logic                           brownout_level_select,
    output logic                           multiplier_enable,
    output cwp_pkg::cwp_guard_t            self_write_guard
);
    import cwp_pkg::*;

    // Nonvolatile storage: blank at power-up, kept through sys_rst
    logic [WORD_W-1:0] word_a       = BLANK_WORD;
    logic [WORD_W-1:0] word_b       = BLANK_WORD;
    logic [WORD_W-1:0] user_id [4]  = '{default: BLANK_WORD};
    logic [WORD_W-1:0] next_word_a;
    logic [WORD_W-1:0] next_word_b;
    logic [WORD_W-1:0] next_user_id [4];
    logic [WORD_W-1:0] shadow_a;
    logic [WORD_W-1:0] shadow_b;
    logic [WORD_W-1:0] next_shadow_a;
    logic [WORD_W-1:0] next_shadow_b;
    logic [WORD_W-1:0] next_ext_rdata;
    logic [WORD_W-1:0] next_cpu_rdata;
    logic              live_pending;
    logic              next_live_pending;
    logic [WORD_W-1:0] identity_word;
    logic              ext_prog_allowed;
    logic              ext_data_allowed;

    // Config space check, used by both access ports
    function automatic logic is_config(input logic [ADDR_W-1:0] a);
        is_config = a[15];
    endfunction

    function automatic logic guard_blocks(input cwp_guard_t g, input logic [ADDR_W-1:0] a);
        case (g)
            GUARD_NONE:  guard_blocks = 1'b0;
            GUARD_SMALL: guard_blocks = a[12:0] <= GUARD_END_SMALL;
            GUARD_HALF:  guard_blocks = a[12:0] <= GUARD_END_HALF;
            default:     guard_blocks = a[12:0] <= GUARD_END_ALL;
        endcase
    endfunction

    assign identity_word = {PART_CODE, REV_CODE};

    // Each protection reads only its own bit of the latched copy
    assign ext_prog_allowed = shadow_a[PROG_PROT_BIT];
    assign ext_data_allowed = shadow_a[DATA_PROT_BIT];

    // Programmer and CPU storage path
    always_comb begin
        next_word_a        = word_a;
        next_word_b        = word_b;
        next_user_id       = user_id;
        next_ext_rdata     = ext_rdata;
        next_cpu_rdata     = cpu_rdata;
        next_live_pending  = live_pending;
        ext_array_read     = 1'b0;
        ext_array_write    = 1'b0;
        ext_refused        = 1'b0;
        cpu_array_read     = 1'b0;
        cpu_array_write    = 1'b0;
        cpu_write_blocked  = 1'b0;
        erase_program_flash = 1'b0;
        erase_data_eeprom  = 1'b0;
        if (prog_mode && ext_bulk_erase) begin
            // Erase of everything also lifts data protection, so EEPROM goes too
            erase_program_flash = 1'b1;
            erase_data_eeprom   = 1'b1;
            next_word_a         = BLANK_WORD;
            next_word_b         = BLANK_WORD;
            next_user_id        = '{default: BLANK_WORD};
        end else if (prog_mode && ext_req) begin
            if (ext_eeprom) begin
                if (!ext_data_allowed) begin
                    ext_refused = 1'b1;
                end else if (ext_write) begin
                    ext_array_write = 1'b1;
                end else begin
                    ext_array_read = 1'b1;
                end
            end else if (is_config(ext_addr)) begin
                if (ext_write) begin
                    if (ext_addr == WORD_A_ADDR) begin
                        // Plain programming only clears bits; data bit 8 can't return to 1
                        next_word_a = word_a & ext_wdata;
                    end else if (ext_addr == WORD_B_ADDR) begin
                        if (prog_entry_low_voltage && !ext_wdata[LV_PROG_BIT] && word_b[LV_PROG_BIT]) begin
                            ext_refused = 1'b1;
                        end else begin
                            next_word_b = (word_b & ext_wdata) | WORD_B_FIXED;
                        end
                    end else if (ext_addr <= USER_ID_LAST) begin
                        next_user_id[ext_addr[1:0]] = ext_wdata;
                    end else begin
                        ext_refused = 1'b1;
                    end
                end else begin
                    if (ext_addr <= USER_ID_LAST) begin
                        next_ext_rdata = user_id[ext_addr[1:0]];
                    end else if (ext_addr == IDENTITY_ADDR) begin
                        next_ext_rdata = identity_word;
                    end else if (ext_addr == WORD_A_ADDR) begin
                        next_ext_rdata = word_a;
                    end else if (ext_addr == WORD_B_ADDR) begin
                        next_ext_rdata = word_b | WORD_B_FIXED;
                    end else begin
                        next_ext_rdata = '0;
                    end
                end
            end else if (!ext_prog_allowed) begin
                ext_refused = ext_write;
                if (!ext_write) begin
                    next_ext_rdata = '0;
                end
            end else if (ext_write) begin
                ext_array_write = 1'b1;
            end else begin
                ext_array_read = 1'b1;
            end
        end
        // Array data lands one cycle after its strobe
        if (live_pending) begin
            next_ext_rdata = ext_array_rdata;
        end
        next_live_pending = ext_array_read;
        if (cpu_req) begin
            if (cpu_eeprom) begin
                cpu_array_read  = !cpu_write;
                cpu_array_write = cpu_write;
            end else if (is_config(cpu_addr)) begin
                if (cpu_write && cpu_addr <= USER_ID_LAST) begin
                    next_user_id[cpu_addr[1:0]] = cpu_wdata;
                end else if (!cpu_write) begin
                    if (cpu_addr <= USER_ID_LAST) begin
                        next_cpu_rdata = user_id[cpu_addr[1:0]];
                    end else if (cpu_addr == IDENTITY_ADDR) begin
                        next_cpu_rdata = identity_word;
                    end else if (cpu_addr == WORD_A_ADDR) begin
                        next_cpu_rdata = word_a;
                    end else if (cpu_addr == WORD_B_ADDR) begin
                        next_cpu_rdata = word_b | WORD_B_FIXED;
                    end else begin
                        next_cpu_rdata = '0;
                    end
                end
            end else if (cpu_write) begin
                cpu_write_blocked = guard_blocks(self_write_guard, cpu_addr);
                cpu_array_write   = !cpu_write_blocked;
            end else begin
                cpu_array_read = 1'b1;
            end
        end
        if (cpu_array_read) begin
            next_cpu_rdata = cpu_array_rdata;
        end
    end

    // A reset must not wipe the option words, or no programmed setting could ever take effect
    always_ff @(posedge clock) begin
        if (clk_en) begin
            word_a       <= next_word_a;
            word_b       <= next_word_b;
            user_id      <= next_user_id;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            ext_rdata    <= '0;
            cpu_rdata    <= '0;
            live_pending <= 1'b0;
        end else if (clk_en) begin
            ext_rdata    <= next_ext_rdata;
            cpu_rdata    <= next_cpu_rdata;
            live_pending <= next_live_pending;
        end
    end

    // Latched copy; the stored words may change while decode stays put
    logic reset_seen;
    logic next_reset_seen;

    always_comb begin
        next_shadow_a   = shadow_a;
        next_shadow_b   = shadow_b;
        next_reset_seen = 1'b1;
        if (!reset_seen) begin
            next_shadow_a = word_a;
            next_shadow_b = word_b | WORD_B_FIXED;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            shadow_a   <= BLANK_WORD;
            shadow_b   <= BLANK_WORD;
            reset_seen <= 1'b0;
        end else if (clk_en) begin
            shadow_a   <= next_shadow_a;
            shadow_b   <= next_shadow_b;
            reset_seen <= next_reset_seen;
        end
    end

    // Decoded controls
    always_comb begin
        oscillator_select        = cwp_osc_t'(shadow_a[OSC_SEL_LSB +: 3]);
        clock_input_pin_is_io    = oscillator_select == OSC_INTERNAL;
        clock_input_pin_is_clock = oscillator_select == OSC_EXT_CLOCK_HIGH ||
                                   oscillator_select == OSC_EXT_CLOCK_MEDIUM ||
                                   oscillator_select == OSC_EXT_CLOCK_LOW;
        resonator_pins_crystal   = oscillator_select <= OSC_HIGH_GAIN_CRYSTAL;
        low_voltage_prog_enable  = shadow_b[LV_PROG_BIT];
        prog_entry_allowed       = low_voltage_prog_enable || master_clear_pin_high_voltage;
        debug_pins_dedicated     = !shadow_b[DEBUG_BIT];
        brownout_level_select    = shadow_b[BROWNOUT_BIT];
        multiplier_enable        = shadow_b[MULT_EN_BIT];
        self_write_guard         = cwp_guard_t'(shadow_b[GUARD_LSB +: 2]);
        stack_fault_reset        = shadow_b[STACK_RST_BIT] && (stack_overflow || stack_underflow);
    end

endmodule

//--- verification/cwp_checker.sv
/*
 Port checker for cwp_decode, bound into every instance.
 Assumes one clock and an async active-high sys_rst.
*/
module cwp_checker (
    // Clock and control
    input wire logic                       clock,
    input wire logic                       sys_rst,
    input wire logic                       clk_en,
    input wire logic                       prog_mode,
    input wire logic                       master_clear_pin_high_voltage,
    // Programmer side
    input wire logic                       ext_bulk_erase,
    input wire logic                       ext_array_read,
    input wire logic                       ext_array_write,
    input wire logic                       ext_refused,
    input wire logic                       erase_program_flash,
    input wire logic                       erase_data_eeprom,
    // CPU side
    input wire logic                       cpu_req,
    input wire logic                       cpu_write,
    input wire logic                       cpu_eeprom,
    input wire logic [cwp_pkg::ADDR_W-1:0] cpu_addr,
    input wire logic                       cpu_array_read,
    input wire logic                       cpu_array_write,
    input wire logic                       cpu_write_blocked,
    // Stack faults and decoded controls
    input wire logic                       stack_overflow,
    input wire logic                       stack_underflow,
    input wire logic                       stack_fault_reset,
    input wire cwp_pkg::cwp_osc_t          oscillator_select,
    input wire logic                       clock_input_pin_is_io,
    input wire logic                       clock_input_pin_is_clock,
    input wire logic                       low_voltage_prog_enable,
    input wire logic                       prog_entry_allowed,
    input wire cwp_pkg::cwp_guard_t        self_write_guard
);
    timeunit 1ns;
    timeprecision 100ps;
    import cwp_pkg::*;
    logic [1:0] settle;
    logic [1:0] next_settle;
    // Two stages: the copy edge itself may still change the decode
    always_comb next_settle = {settle[0], settle[0] | clk_en};
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            settle <= 2'h0;
        end else begin
            settle <= next_settle;
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    a_pin_io_mode: assert property (clock_input_pin_is_io == (oscillator_select == OSC_INTERNAL))
        else $error("clock pin io mismatch");
    a_pin_clock_mode: assert property (clock_input_pin_is_clock == (oscillator_select[2] && |oscillator_select[1:0]))
        else $error("clock pin clock mismatch");
    a_bulk_erase_all: assert property (clk_en && prog_mode && ext_bulk_erase |-> erase_program_flash && erase_data_eeprom)
        else $error("bulk erase incomplete");
    a_entry_gate: assert property (prog_entry_allowed == (low_voltage_prog_enable || master_clear_pin_high_voltage))
        else $error("entry gate wrong");
    a_stack_cause: assert property (stack_fault_reset |-> stack_overflow || stack_underflow)
        else $error("stack reset without fault");
    a_cpu_read_free: assert property (clk_en && cpu_req && !cpu_write && !cpu_addr[15] |-> cpu_array_read)
        else $error("cpu read held back");
    a_cpu_eeprom_wr: assert property (clk_en && cpu_req && cpu_write && cpu_eeprom && !cpu_addr[15] |-> cpu_array_write)
        else $error("cpu eeprom write held back");
    a_guard_no_write: assert property (cpu_write_blocked |-> cpu_req && cpu_write && !cpu_eeprom && !cpu_array_write)
        else $error("guarded write leaked");
    a_refuse_no_strobe: assert property (ext_refused |-> !ext_array_write && !ext_array_read)
        else $error("refused access strobed");
    a_decode_hold: assert property (settle[1] |-> $stable(oscillator_select) && $stable(self_write_guard))
        else $error("decode changed between resets");
endmodule
bind cwp_decode cwp_checker cwp_checker_inst (.clock, .sys_rst, .clk_en, .prog_mode, .master_clear_pin_high_voltage,
    .ext_bulk_erase, .ext_array_read, .ext_array_write, .ext_refused, .erase_program_flash, .erase_data_eeprom,
    .cpu_req, .cpu_write, .cpu_eeprom, .cpu_addr, .cpu_array_read, .cpu_array_write, .cpu_write_blocked,
    .stack_overflow, .stack_underflow, .stack_fault_reset, .oscillator_select, .clock_input_pin_is_io,
    .clock_input_pin_is_clock, .low_voltage_prog_enable, .prog_entry_allowed, .self_write_guard);

//--- verification/cwp_array_model.sv
/*
 Program flash and data EEPROM arrays behind the decoder.
 Assumes reads answer one cycle late on the programmer side, at once on the CPU side.
*/
module cwp_array_model (
    input  wire logic                       clock,
    input  wire logic                       ext_array_read,
    input  wire logic [cwp_pkg::ADDR_W-1:0] ext_addr,
    input  wire logic                       cpu_array_read,
    input  wire logic [cwp_pkg::ADDR_W-1:0] cpu_addr,
    output logic      [cwp_pkg::WORD_W-1:0] ext_array_rdata,
    output logic      [cwp_pkg::WORD_W-1:0] cpu_array_rdata
);
    timeunit 1ns;
    timeprecision 100ps;
    import cwp_pkg::*;
    logic [WORD_W-1:0] noise = 14'h1234;
    // Idle data walks every cycle so a stale sample never matches by luck
    always_ff @(posedge clock) begin
        noise <= noise + 14'h0B5D;
        ext_array_rdata <= ext_array_read ? ext_addr[13:0] ^ 14'h2A5A : ~noise;
    end
    assign cpu_array_rdata = cpu_array_read ? cpu_addr[13:0] ^ 14'h2A5A : noise;
endmodule

//--- verification/cwp_decode_tb_top.sv
/*
 Self-checking bench for cwp_decode with the array model beside it.
 Assumes option words survive sys_rst, as nonvolatile storage does.
*/
module cwp_decode_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import cwp_pkg::*;
    localparam logic [8:0] PART = 9'h0B6;  // Arbitrary value
    localparam logic [4:0] REV  = 5'h0D;   // Arbitrary value
    logic clock = 0, sys_rst = 1, clk_en = 1, prog_mode = 1, prog_entry_low_voltage = 0;
    logic master_clear_pin_high_voltage = 0, ext_req = 0, ext_write = 0, ext_eeprom = 0, ext_bulk_erase = 0;
    logic cpu_req = 0, cpu_write = 0, cpu_eeprom = 0, stack_overflow = 0, stack_underflow = 0;
    logic [ADDR_W-1:0] ext_addr = '0, cpu_addr = '0, pa, ea;
    logic [WORD_W-1:0] ext_wdata = '0, cpu_wdata = '0, ext_array_rdata, cpu_array_rdata, ext_rdata, cpu_rdata;
    logic ext_array_read, ext_array_write, ext_refused, erase_program_flash, erase_data_eeprom, rf;
    logic cpu_array_read, cpu_array_write, cpu_write_blocked, stack_fault_reset, clock_input_pin_is_io;
    logic clock_input_pin_is_clock, resonator_pins_crystal, low_voltage_prog_enable, prog_entry_allowed;
    logic debug_pins_dedicated, brownout_level_select, multiplier_enable;
    cwp_osc_t oscillator_select;
    cwp_guard_t self_write_guard;
    int errors = 0, tests_run = 0;
    logic [31:0] seed = 32'd67675;
    logic [13:0] rd, wa, wb;
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin errors++; \
    $display("BAD %0t got %h want %h", $time, got, exp); end end
    initial forever #2.5 clock = ~clock;
    cwp_decode #(.PART_CODE(PART), .REV_CODE(REV)) cwp_decode_inst (.clock, .sys_rst, .clk_en, .prog_mode,
        .prog_entry_low_voltage, .master_clear_pin_high_voltage, .ext_req, .ext_write, .ext_eeprom, .ext_addr,
        .ext_wdata, .ext_bulk_erase, .ext_array_rdata, .ext_rdata, .ext_array_read, .ext_array_write, .ext_refused,
        .erase_program_flash, .erase_data_eeprom, .cpu_req, .cpu_write, .cpu_eeprom, .cpu_addr, .cpu_wdata,
        .cpu_array_rdata, .cpu_rdata, .cpu_array_read, .cpu_array_write, .cpu_write_blocked, .stack_overflow,
        .stack_underflow, .stack_fault_reset, .oscillator_select, .clock_input_pin_is_io, .clock_input_pin_is_clock,
        .resonator_pins_crystal, .low_voltage_prog_enable, .prog_entry_allowed, .debug_pins_dedicated,
        .brownout_level_select, .multiplier_enable, .self_write_guard);
    cwp_array_model cwp_array_model_inst (.clock, .ext_array_read, .ext_addr, .cpu_array_read, .cpu_addr,
        .ext_array_rdata, .cpu_array_rdata);
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [13:0] pat(input logic [15:0] a);
        return a[13:0] ^ 14'h2A5A;
    endfunction
    function automatic logic guarded(input logic [1:0] g, input logic [12:0] a);
        return g == 2'h0 || (g == 2'h1 && a <= 13'h0FFF) || (g == 2'h2 && a <= 13'h01FF);
    endfunction
    // One access on either port; the answer is taken one edge after the request is taken
    task automatic op(input logic cpu, w, ee, input logic [15:0] a, input logic [13:0] d);
        @(posedge clock);
        if (cpu) begin
            {cpu_req, cpu_write, cpu_eeprom, cpu_addr, cpu_wdata} <= {1'b1, w, ee, a, d};
        end else begin
            {ext_req, ext_write, ext_eeprom, ext_addr, ext_wdata} <= {1'b1, w, ee, a, d};
        end
        #1 rf = cpu ? cpu_write_blocked : ext_refused;
        @(posedge clock);
        {cpu_req, ext_req} <= 2'h0;
        @(posedge clock);
        #1 rd = cpu ? cpu_rdata : ext_rdata;
    endtask
    task automatic bulk();
        @(posedge clock);
        ext_bulk_erase <= 1;
        #1 `CHK({erase_program_flash, erase_data_eeprom}, 2'h3)
        @(posedge clock);
        ext_bulk_erase <= 0;
    endtask
    task automatic do_reset();
        @(posedge clock);
        sys_rst <= 1;
        repeat (10) @(posedge clock);
        sys_rst <= 0;
        repeat (2) @(posedge clock);
    endtask
    task automatic summarize();
        $display("errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        #200000;
        errors++;
        summarize();
    end
    initial begin
        do_reset();
        op(0, 0, 0, 16'h8006, 14'h0);
        `CHK(rd, {PART, REV})
        op(0, 1, 0, 16'h8006, 14'h0);
        `CHK(rf, 1'b1)
        for (int i = 0; i < 8; i++) begin
            master_clear_pin_high_voltage <= i[0];
            bulk();
            op(0, 0, 0, 16'h8007, 14'h0);
            `CHK(rd, 14'h3FFF)
            seed = lfsr(seed);
            wa = {5'h1F, !i[1], i[0], 4'hF, i[2:0]};
            wb = seed[13:0] | 14'h0010;
            op(0, 1, 0, 16'h8007, wa);
            op(0, 1, 0, 16'h8008, wb);
            op(0, 0, 0, 16'h8008, 14'h0);
            `CHK(rd, wb | 14'h08EC)
            do_reset();
            `CHK(oscillator_select, cwp_osc_t'(i[2:0]))
            `CHK({clock_input_pin_is_io, clock_input_pin_is_clock, resonator_pins_crystal}, {i == 4, i > 4, i < 3})
            `CHK({low_voltage_prog_enable, prog_entry_allowed, debug_pins_dedicated}, {wb[13], wb[13] | i[0], !wb[12]})
            `CHK({brownout_level_select, multiplier_enable, self_write_guard}, {wb[10], wb[8], wb[1:0]})
            @(posedge clock);
            {stack_overflow, stack_underflow} <= {i[0], !i[0]};
            #1 `CHK(stack_fault_reset, wb[9])
            seed = lfsr(seed);
            pa = {3'h0, seed[12:0]};
            ea = {8'h00, seed[20:13]};
            op(0, 0, 0, pa, 14'h0);
            `CHK(rd, i[0] ? pat(pa) : 14'h0)
            op(0, 1, 0, pa, wb);
            `CHK(rf, !i[0])
            op(0, 0, 1, ea, 14'h0);
            `CHK(rf, i[1])
            if (!i[1]) `CHK(rd, pat(ea))
            op(1, 0, 1, ea, 14'h0);
            `CHK(rd, pat(ea))
            op(1, 0, 0, pa, 14'h0);
            `CHK(rd, pat(pa))
            op(1, 1, 0, pa, wb);
            `CHK(rf, guarded(wb[1:0], pa[12:0]))
        end
        prog_entry_low_voltage <= 1;
        bulk();
        op(0, 1, 0, 16'h8008, 14'h1FFF);
        `CHK(rf, 1'b1)
        do_reset();
        op(0, 0, 1, 16'h0010, 14'h0);
        `CHK({rf, rd}, {1'b0, pat(16'h0010)})
        op(1, 1, 0, 16'h8002, wb);
        op(1, 0, 0, 16'h8002, 14'h0);
        `CHK(rd, wb)
        op(0, 0, 0, 16'h8002, 14'h0);
        `CHK(rd, wb)
        summarize();
    end
endmodule
